// ---- logic/tsa_consts.svh ----
// offsets, field positions and reset values of the slot assignment block
// assumes: included by the design file and the test bench by bare name
`ifndef TSA_CONSTS_SVH
`define TSA_CONSTS_SVH

// ======================================================================
// register byte offsets
`define TSA_OFS_CTRL 12'h000
`define TSA_OFS_STATUS 12'h004
`define TSA_OFS_SEL 12'h008
`define TSA_OFS_ENTRY 12'h00c
`define TSA_OFS_CRC 12'h010

// ======================================================================
// control / status fields
`define TSA_CTRL_CYCDEP 0
`define TSA_CTRL_UNLOCK 1
`define TSA_STAT_IGNORED 0
`define TSA_STAT_POC_LO 4
`define TSA_STAT_POC_HI 5

// ======================================================================
// entry fields
`define TSA_ENT_VALID 0
`define TSA_ENT_CH_LO 1
`define TSA_ENT_CH_HI 2
`define TSA_ENT_KEY 3
`define TSA_ENT_CYCDEP 4
`define TSA_ENT_DYN 5
`define TSA_ENT_SLOT_LO 6
`define TSA_ENT_SLOT_HI 16
`define TSA_ENT_BASE_LO 17
`define TSA_ENT_BASE_HI 22
`define TSA_ENT_REP_LO 23
`define TSA_ENT_REP_HI 25
`define TSA_CRC_HI 10

// ======================================================================
// reset values: list locked, cycle-dependent static assignment off
`define TSA_RST_CYCDEP 1'b0
`define TSA_RST_UNLOCK 1'b0

`endif

// ---- logic/tsa_pkg.sv ----
// types shared by the slot assignment block and its surroundings
// assumes: nothing beyond the constants header
package tsa_pkg;

  // ====================================================================
  // controller state as reported by the protocol engine
  typedef enum logic [1:0] {
    TSA_DEFAULT_CONFIG,
    TSA_CONFIG,
    TSA_NORMAL_ACTIVE,
    TSA_OTHER_STATE
  } tsa_poc_e;

  typedef enum logic [1:0] {
    TSA_SEND_NONE,
    TSA_SEND_NULL,
    TSA_SEND_DATA
  } tsa_kind_e;

  // ====================================================================
  // one assignment list entry
  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    logic key;
    logic cycdep;
    logic dyn;
    logic [10:0] slot;
    logic [5:0] base;
    logic [2:0] rep;
    logic [10:0] crc;
  } tsa_entry_s;

  // slot announced by the protocol engine
  typedef struct packed {
    logic [10:0] slot;
    logic [5:0] cycle;
    logic dyn;
  } tsa_slot_s;

  // per-channel answer to the protocol engine
  typedef struct packed {
    logic assigned;
    tsa_kind_e kind;
    logic [10:0] crc;
    logic [7:0] idx;
  } tsa_tx_s;

endpackage : tsa_pkg

// ---- logic/tsa_ctrl.sv ----
// transmit slot assignment list with apb register access
// assumes: apb master on pclk; protocol engine logic on the same clock
//
// Functional notes
// - each channel gets its own assignment answer
// - normal active: every assigned static slot sends
// - static: null frame if no data/buffer
// - dynamic: data only with active buffer
// - cycle-independent entries match every cycle
// - cycle-dependent entries: slot plus cycle set
// - host bit enables cycle-dependent static entries
// - that bit written only in configuration
// - disabled: static entries act cycle-independent
// - key slots never cycle multiplexed
// - base/repetition covers every buffer cycle set
// - answer presented at each slot start
// - every entry holds its own header crc
// - list frozen in default configuration
// - lock bit changes only in configuration
// - outside configuration, writes need explicit unlock
// - key slots: all channels, every cycle
// - key changes outside configuration ignored, flagged in status
// - sync frames need no receive entry here
//
// Implementation choices: the register addresses and the APB register port.
`include "tsa_consts.svh"

module tsa_ctrl
  import tsa_pkg::*;
#(
  parameter int NUM_ENTRIES = 16,
  parameter int NUM_CH = 2
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tsa_poc_e poc_state,
  input wire logic slot_start,
  input wire tsa_slot_s slot_info,
  input wire logic [NUM_CH-1:0] buf_cfg,
  input wire logic [NUM_CH-1:0] buf_ready,
  output logic tx_valid,
  output tsa_tx_s [NUM_CH-1:0] tx_res
);

  localparam int IW = $clog2(NUM_ENTRIES);

  // ====================================================================
  // bus decode
  logic setup;
  logic wr_acc;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_sel;
  logic hit_ent;
  logic hit_crc;
  logic mapped;

  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign hit_ctrl = paddr == `TSA_OFS_CTRL;
  assign hit_stat = paddr == `TSA_OFS_STATUS;
  assign hit_sel = paddr == `TSA_OFS_SEL;
  assign hit_ent = paddr == `TSA_OFS_ENTRY;
  assign hit_crc = paddr == `TSA_OFS_CRC;
  assign mapped = hit_ctrl | hit_stat | hit_sel | hit_ent | hit_crc;

  // zero-wait slave; only unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ====================================================================
  // state held for software
  logic cycdep_en_q;
  logic unlock_q;
  logic ignored_q;
  logic [IW-1:0] sel_q;
  tsa_entry_s ent_q [NUM_ENTRIES];
  logic [31:0] prdata_q;

  logic in_dflt;
  logic in_cfg;
  assign in_dflt = poc_state == TSA_DEFAULT_CONFIG;
  assign in_cfg = poc_state == TSA_CONFIG;

  // ====================================================================
  // control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cycdep_en_q <= `TSA_RST_CYCDEP;
      unlock_q <= `TSA_RST_UNLOCK;
    end
    else if (wr_acc && hit_ctrl && in_cfg)
    begin
      cycdep_en_q <= pwdata[`TSA_CTRL_CYCDEP];
      unlock_q <= pwdata[`TSA_CTRL_UNLOCK];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sel_q <= '0;
    else if (wr_acc && hit_sel)
      sel_q <= pwdata[IW-1:0];
  end

  // ====================================================================
  // write permission for the selected entry
  tsa_entry_s cur;
  tsa_entry_s nxt;
  logic ent_ok;
  logic crc_ok;
  logic bad_form;
  logic may_touch;

  always_comb
  begin
    cur = ent_q[sel_q];
    nxt = cur;
    nxt.valid = pwdata[`TSA_ENT_VALID];
    nxt.chan = pwdata[`TSA_ENT_CH_HI:`TSA_ENT_CH_LO];
    nxt.key = pwdata[`TSA_ENT_KEY];
    nxt.cycdep = pwdata[`TSA_ENT_CYCDEP];
    nxt.dyn = pwdata[`TSA_ENT_DYN];
    nxt.slot = pwdata[`TSA_ENT_SLOT_HI:`TSA_ENT_SLOT_LO];
    nxt.base = pwdata[`TSA_ENT_BASE_HI:`TSA_ENT_BASE_LO];
    nxt.rep = pwdata[`TSA_ENT_REP_HI:`TSA_ENT_REP_LO];
  end

  // key entries, old or new, move only in configuration
  assign may_touch = ~in_dflt &
    (in_cfg | (unlock_q & ~cur.key));
  // key slots cannot be multiplexed; static multiplexing needs the enable
  assign bad_form = (nxt.key & (nxt.cycdep | nxt.dyn)) |
    (~nxt.dyn & nxt.cycdep & ~cycdep_en_q);
  assign ent_ok = may_touch & (in_cfg | ~nxt.key) & ~bad_form;
  assign crc_ok = may_touch;

  logic ent_wr;
  logic crc_wr;
  assign ent_wr = wr_acc & hit_ent & ent_ok;
  assign crc_wr = wr_acc & hit_crc & crc_ok;

  // ====================================================================
  // assignment list storage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_ENTRIES; i++)
        ent_q[i] <= '0;
    end
    else if (ent_wr)
      ent_q[sel_q] <= nxt;
    else if (crc_wr)
      ent_q[sel_q].crc <= pwdata[`TSA_CRC_HI:0];
  end

  // ====================================================================
  // sticky flag: a list or control write was dropped; set wins over clear
  logic drop;
  assign drop = wr_acc & ((hit_ent & ~ent_ok) | (hit_crc & ~crc_ok) |
    (hit_ctrl & ~in_cfg));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ignored_q <= 1'b0;
    else if (drop)
      ignored_q <= 1'b1;
    else if (wr_acc && hit_stat && pwdata[`TSA_STAT_IGNORED])
      ignored_q <= 1'b0;
  end

  // ====================================================================
  // read data, captured in the setup phase
  logic [31:0] rd;

  always_comb
  begin
    rd = '0;
    if (hit_ctrl)
    begin
      rd[`TSA_CTRL_CYCDEP] = cycdep_en_q;
      rd[`TSA_CTRL_UNLOCK] = unlock_q;
    end
    else if (hit_stat)
    begin
      rd[`TSA_STAT_IGNORED] = ignored_q;
      rd[`TSA_STAT_POC_HI:`TSA_STAT_POC_LO] = poc_state;
    end
    else if (hit_sel)
      rd[IW-1:0] = sel_q;
    else if (hit_ent)
    begin
      rd[`TSA_ENT_VALID] = cur.valid;
      rd[`TSA_ENT_CH_HI:`TSA_ENT_CH_LO] = cur.chan;
      rd[`TSA_ENT_KEY] = cur.key;
      rd[`TSA_ENT_CYCDEP] = cur.cycdep;
      rd[`TSA_ENT_DYN] = cur.dyn;
      rd[`TSA_ENT_SLOT_HI:`TSA_ENT_SLOT_LO] = cur.slot;
      rd[`TSA_ENT_BASE_HI:`TSA_ENT_BASE_LO] = cur.base;
      rd[`TSA_ENT_REP_HI:`TSA_ENT_REP_LO] = cur.rep;
    end
    else if (hit_crc)
      rd[`TSA_CRC_HI:0] = cur.crc;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= '0;
    else if (setup && !pwrite)
      prdata_q <= rd;
  end

  assign prdata = prdata_q;

  // ====================================================================
  // lookup: lowest matching index wins per channel
  // cycle set is base modulo 2**rep, covering every repetition a
  // transmit buffer can be given
  function automatic logic cyc_hit(input tsa_entry_s e,
                                   input logic [5:0] cyc,
                                   input logic dep_en);
    logic [5:0] m;
    logic dep;
    m = 6'h3f >> (3'd6 - ((e.rep > 3'd6) ? 3'd6 : e.rep));
    dep = e.cycdep & ~e.key & (e.dyn | dep_en);
    cyc_hit = !dep || ((cyc & m) == (e.base & m));
  endfunction : cyc_hit

  logic [NUM_CH-1:0] hit;
  logic [IW-1:0] hit_idx [NUM_CH];

  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      hit[c] = 1'b0;
      hit_idx[c] = '0;
      for (int i = NUM_ENTRIES - 1; i >= 0; i--)
      begin
        // key entries apply to every connected channel
        if (ent_q[i].valid &&
            (ent_q[i].chan[c] || ent_q[i].key) &&
            ent_q[i].slot == slot_info.slot &&
            ent_q[i].dyn == slot_info.dyn &&
            cyc_hit(ent_q[i], slot_info.cycle, cycdep_en_q))
        begin
          hit[c] = 1'b1;
          hit_idx[c] = IW'(i);
        end
      end
    end
  end

  // ====================================================================
  // answer to the protocol engine, one cycle after each slot start
  // reception is not looked up: sync frames are the engine's own job
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_valid <= 1'b0;
      tx_res <= '0;
    end
    else
    begin
      tx_valid <= slot_start;
      if (slot_start)
      begin
        for (int c = 0; c < NUM_CH; c++)
        begin
          tx_res[c].assigned <= hit[c];
          tx_res[c].crc <= ent_q[hit_idx[c]].crc;
          tx_res[c].idx <= 8'(hit_idx[c]);
          if (!hit[c] || poc_state != TSA_NORMAL_ACTIVE)
            tx_res[c].kind <= TSA_SEND_NONE;
          else if (slot_info.dyn)
            tx_res[c].kind <= (buf_cfg[c] && buf_ready[c]) ?
              TSA_SEND_DATA : TSA_SEND_NONE;
          else
            tx_res[c].kind <= (buf_cfg[c] && buf_ready[c]) ?
              TSA_SEND_DATA : TSA_SEND_NULL;
        end
      end
    end
  end

endmodule : tsa_ctrl

// ---- dv/tsa_ctrl_sva.sv ----
// assertions on the ports of the slot assignment block
// assumes: bound to tsa_ctrl, one clock domain
module tsa_ctrl_sva
  import tsa_pkg::*;
#(
  parameter int NUM_CH = 2
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire tsa_poc_e poc_state,
  input wire logic slot_start,
  input wire tsa_slot_s slot_info,
  input wire logic [NUM_CH-1:0] buf_ready,
  input wire logic tx_valid,
  input wire tsa_tx_s [NUM_CH-1:0] tx_res
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic na;
  assign na = poc_state == TSA_NORMAL_ACTIVE;

  // ======================================================================
  // answer to each slot start
  property p_ans;
    slot_start |=> tx_valid;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_quiet;
    !slot_start |=> !tx_valid && $stable(tx_res);
  endproperty
  a_quiet: assert property (p_quiet) else $error("answer moved");
  property p_idle;
    slot_start && !na |=>
      tx_res[0].kind == TSA_SEND_NONE && tx_res[1].kind == TSA_SEND_NONE;
  endproperty
  a_idle: assert property (p_idle) else $error("sent while idle");
  property p_send;
    slot_start && na && !slot_info.dyn |=>
      !tx_res[0].assigned || tx_res[0].kind != TSA_SEND_NONE;
  endproperty
  a_send: assert property (p_send) else $error("static slot silent");
  property p_null;
    slot_start && na && !slot_info.dyn && !buf_ready[0] |=>
      !tx_res[0].assigned || tx_res[0].kind == TSA_SEND_NULL;
  endproperty
  a_null: assert property (p_null) else $error("null frame missing");
  property p_dyn;
    slot_start && slot_info.dyn && !buf_ready[0] |=>
      tx_res[0].kind != TSA_SEND_DATA;
  endproperty
  a_dyn: assert property (p_dyn) else $error("data without buffer");
  property p_unas;
    slot_start |=> tx_res[1].assigned || tx_res[1].kind == TSA_SEND_NONE;
  endproperty
  a_unas: assert property (p_unas) else $error("unassigned send");
  property p_dynnull;
    slot_start && slot_info.dyn |=> tx_res[1].kind != TSA_SEND_NULL;
  endproperty
  a_dynnull: assert property (p_dynnull) else $error("dynamic null");

  c_data: cover property (slot_start && na ##1
    tx_res[0].kind == TSA_SEND_DATA);
  c_null: cover property (slot_start && na ##1
    tx_res[0].kind == TSA_SEND_NULL);
  c_key: cover property (slot_start ##1
    tx_res[0].assigned && tx_res[1].assigned);
endmodule : tsa_ctrl_sva

bind tsa_ctrl tsa_ctrl_sva #(.NUM_CH(NUM_CH)) chk_u (
  .pclk(pclk),
  .presetn(presetn),
  .poc_state(poc_state),
  .slot_start(slot_start),
  .slot_info(slot_info),
  .buf_ready(buf_ready),
  .tx_valid(tx_valid),
  .tx_res(tx_res)
);

// ---- dv/tsa_eng_model.sv ----
// protocol engine stand-in: announces slots with buffer state
// assumes: the block samples an announcement at the next rising edge
module tsa_eng_model
  import tsa_pkg::*;
(
  input wire logic pclk,
  output logic slot_start,
  output tsa_slot_s slot_info,
  output logic [1:0] buf_cfg,
  output logic [1:0] buf_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    slot_start = 1'b0;
    slot_info = '0;
    buf_cfg = 2'h0;
    buf_ready = 2'h0;
  end

  // lines are inverted after the pulse so stale values never pass
  task automatic announce(input logic [10:0] s, input logic [5:0] c,
                          input logic d, input logic [1:0] r);
    @(posedge pclk);
    slot_start <= 1'b1;
    slot_info <= '{s, c, d};
    buf_cfg <= r;
    buf_ready <= r;
    @(posedge pclk);
    slot_start <= 1'b0;
    slot_info <= ~slot_info;
    buf_cfg <= ~r;
    buf_ready <= ~r;
  endtask : announce
endmodule : tsa_eng_model

// ---- dv/tx_slot_assignment_control_test.sv ----
// self-checking bench for the slot assignment block
// assumes: zero-wait apb slave, slot answer one cycle after slot start
`include "tsa_consts.svh"
module tx_slot_assignment_control_test
  import tsa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, e;
  logic slot_start, tx_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] buf_cfg, buf_ready;
  tsa_poc_e poc_state;
  tsa_slot_s slot_info;
  tsa_tx_s [1:0] tx_res;
  int err_total = 0;
  int checked = 0;

  always #5 pclk = ~pclk;

  tsa_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .poc_state(poc_state), .slot_start(slot_start),
    .slot_info(slot_info), .buf_cfg(buf_cfg), .buf_ready(buf_ready),
    .tx_valid(tx_valid), .tx_res(tx_res));
  tsa_eng_model eng_u (.pclk(pclk), .slot_start(slot_start),
    .slot_info(slot_info), .buf_cfg(buf_cfg), .buf_ready(buf_ready));

  // ======================================================================
  // helpers
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      err_total++;
      end_sim();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    cmp(q, x);
  endtask : rd
  // f = {dyn, cycdep, key}
  function automatic logic [31:0] ent(input logic [10:0] s,
    input logic [1:0] ch, input logic [2:0] f, input logic [5:0] b,
    input logic [2:0] r);
    return {6'h00, r, b, s, f, ch, 1'b1};
  endfunction : ent
  task automatic put(input logic [31:0] i, input logic [31:0] d,
                     input logic [31:0] crc);
    apb(1'b1, `TSA_OFS_SEL, i);
    apb(1'b1, `TSA_OFS_ENTRY, d);
    apb(1'b1, `TSA_OFS_CRC, crc);
  endtask : put
  task automatic slot(input logic [10:0] s, input logic [5:0] c,
    input logic d, input logic [1:0] r, input tsa_kind_e ka, kb);
    eng_u.announce(s, c, d, r);
    #1;
    cmp(tx_valid, 1'b1);
    cmp(tx_res[0].kind, ka);
    cmp(tx_res[1].kind, kb);
  endtask : slot

  // ======================================================================
  // scenarios
  task automatic t_locked();
    rd(`TSA_OFS_CTRL, 32'h0);
    put(0, ent(5, 2'h1, 3'h0, 6'h0, 3'h0), 32'h2a5);
    rd(`TSA_OFS_STATUS, 32'h1);
    apb(1'b0, 12'h020, 32'h0);
    cmp(e, 1'b1);
    $display("test locked done");
  endtask : t_locked
  task automatic t_config();
    @(posedge pclk);
    poc_state <= TSA_CONFIG;
    apb(1'b1, `TSA_OFS_STATUS, 32'h1);
    put(1, ent(9, 2'h2, 3'h2, 6'h1, 3'h1), 32'h0);
    rd(`TSA_OFS_STATUS, 32'h11);
    apb(1'b1, `TSA_OFS_STATUS, 32'h1);
    put(0, ent(5, 2'h1, 3'h0, 6'h0, 3'h0), 32'h2a5);
    put(1, ent(7, 2'h0, 3'h1, 6'h0, 3'h0), 32'h111);
    put(2, ent(20, 2'h1, 3'h4, 6'h0, 3'h0), 32'h0);
    apb(1'b1, `TSA_OFS_CTRL, 32'h3);
    rd(`TSA_OFS_CTRL, 32'h3);
    put(3, ent(9, 2'h2, 3'h2, 6'h1, 3'h1), 32'h0f0);
    // a key entry may not be cycle dependent, even with the enable set
    apb(1'b1, `TSA_OFS_STATUS, 32'h1);
    put(6, ent(15, 2'h1, 3'h3, 6'h0, 3'h0), 32'h0);
    rd(`TSA_OFS_STATUS, 32'h11);
    slot(5, 0, 0, 2'h1, TSA_SEND_NONE, TSA_SEND_NONE);
    $display("test config done");
  endtask : t_config
  task automatic t_active();
    @(posedge pclk);
    poc_state <= TSA_NORMAL_ACTIVE;
    apb(1'b1, `TSA_OFS_CTRL, 32'h0);
    rd(`TSA_OFS_CTRL, 32'h3);
    // clear first so that only the key write can set the flag again
    apb(1'b1, `TSA_OFS_STATUS, 32'h1);
    put(4, ent(11, 2'h3, 3'h1, 6'h0, 3'h0), 32'h0);
    rd(`TSA_OFS_STATUS, 32'h21);
    slot(11, 0, 0, 2'h0, TSA_SEND_NONE, TSA_SEND_NONE);
    put(5, ent(13, 2'h1, 3'h0, 6'h0, 3'h0), 32'h0);
    slot(13, 0, 0, 2'h0, TSA_SEND_NULL, TSA_SEND_NONE);
    slot(5, 3, 0, 2'h1, TSA_SEND_DATA, TSA_SEND_NONE);
    cmp(tx_res[0].crc, 32'h2a5);
    slot(5, 4, 0, 2'h0, TSA_SEND_NULL, TSA_SEND_NONE);
    slot(7, 2, 0, 2'h0, TSA_SEND_NULL, TSA_SEND_NULL);
    cmp(tx_res[1].idx, 32'h1);
    slot(15, 0, 0, 2'h0, TSA_SEND_NONE, TSA_SEND_NONE);
    slot(9, 3, 0, 2'h0, TSA_SEND_NONE, TSA_SEND_NULL);
    slot(9, 4, 0, 2'h0, TSA_SEND_NONE, TSA_SEND_NONE);
    slot(20, 1, 1, 2'h0, TSA_SEND_NONE, TSA_SEND_NONE);
    slot(20, 1, 1, 2'h1, TSA_SEND_DATA, TSA_SEND_NONE);
    $display("test active done");
  endtask : t_active
  // mid-run reset: list and control must come back restrictive
  task automatic t_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`TSA_OFS_CTRL, 32'h0);
    slot(5, 3, 0, 2'h1, TSA_SEND_NONE, TSA_SEND_NONE);
    $display("test reset done");
  endtask : t_reset

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    poc_state = TSA_DEFAULT_CONFIG;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_locked();
    t_config();
    t_active();
    t_reset();
    end_sim();
  end
endmodule : tx_slot_assignment_control_test
